// ==== core/adme_pkg.sv ====
`default_nettype none
package adme_pkg;

  // Register indices: the control register index is not word aligned, so the byte
  // address is four times the index.
  localparam logic [11:0] CTRL_INDEX  = 12'h00e1;
  localparam logic [11:0] CTRL_ADDR   = {CTRL_INDEX[9:0], 2'b00};
  localparam logic [11:0] STEP_ADDR   = 12'h03f0;
  localparam logic [11:0] EST_ADDR    = 12'h03f4;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;

  // Field positions inside the control word.
  localparam int SYL_LSB    = 13;
  localparam int RANGE_LSB  = 11;
  localparam int MINSEL_BIT = 10;
  localparam int RULE_LSB   = 8;
  localparam int EST_LSB    = 5;

  localparam int SAMPLE_W   = 16;
  localparam int CALC_W     = 20;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [15:0] STEP_RESET    = 16'h0014;
  localparam logic [15:0] EST_RESET     = 16'h0000;

  // Per-bit leak coefficient in 1/65536 units, equal to 3*65536/N. A time constant of
  // N/(3*rate) ms is N/3 bit periods, so the coefficient does not depend on the rate.
  function automatic logic [15:0] syl_coef(input logic [2:0] code);
    case (code)
      3'h0:    return 16'h0180;
      3'h1:    return 16'h0100;
      3'h2:    return 16'h00c0;
      3'h3:    return 16'h0080;
      3'h4:    return 16'h0060;
      3'h5:    return 16'h0040;
      3'h6:    return 16'h0030;
      default: return 16'h0020;
    endcase
  endfunction

  // Codes above four are undefined; they fall back to the slowest defined decay.
  function automatic logic [15:0] est_coef(input logic [2:0] code);
    case (code)
      3'h0:    return 16'h3000;
      3'h1:    return 16'h2000;
      3'h2:    return 16'h1800;
      3'h3:    return 16'h1000;
      default: return 16'h0c00;
    endcase
  endfunction

  function automatic logic [15:0] max_step(input logic [1:0] code);
    case (code)
      2'h0:    return 16'h2800;
      2'h1:    return 16'h1400;
      2'h2:    return 16'h0a00;
      default: return 16'h0500;
    endcase
  endfunction

  function automatic logic [15:0] min_step(input logic sel);
    return sel ? 16'h000a : 16'h0014;
  endfunction

  function automatic logic [2:0] run_length(input logic [1:0] code);
    return 3'(code) + 3'h3;
  endfunction

endpackage
`default_nettype wire

// ==== core/adme_run_detect.sv ====
`timescale 1ns/100ps
`default_nettype none
module adme_run_detect
  import adme_pkg::*;
#(
  parameter int HIST_W = 5
)(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       bit_in,
  input  wire logic       bit_valid,
  input  wire logic [2:0] run_len,
  output logic            run_met
);

  logic [HIST_W-1:0] hist_q;
  logic [2:0]        fill_q;
  logic [2:0]        fill_d;
  logic              all_same;

  // The newest bit counts as one of the run, so only run_len-1 older bits are checked.
  function automatic logic history_matches(input logic [HIST_W-1:0] hist,
                                           input logic              b,
                                           input logic [2:0]        len);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < HIST_W; i++)
    begin
      if ((3'(i) < len - 3'h1) && (hist[i] != b))
        ok = 1'b0;
    end
    return ok;
  endfunction

  assign all_same = history_matches(hist_q, bit_in, run_len);
  assign run_met  = all_same && (fill_q >= run_len - 3'h1);
  assign fill_d   = (fill_q == 3'(HIST_W)) ? fill_q : fill_q + 3'h1;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hist_q <= '0;
      fill_q <= 3'h0;
    end
    else if (bit_valid)
    begin
      hist_q <= {hist_q[HIST_W-2:0], bit_in};
      fill_q <= fill_d;
    end
  end

endmodule
`default_nettype wire

// ==== core/adme_encoder_core.sv ====
// Behaviour
// - Bits 15-13 pick the syllabic time constant.
// - Bits 12-10 pick maximum and minimum step.
// - Limits apply on a signed 16-bit word.
// - Bits 9-8 pick run length three to six.
// - Step grows only after a full identical run; the clamp also lifts it to a raised minimum.
// - Bits 7-5 pick estimator decay time constant.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module adme_encoder_core
  import adme_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          hsel,
  input  wire logic [ADDR_W-1:0]             haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic [adme_pkg::SAMPLE_W-1:0] sample_in,
  input  wire logic                          sample_valid,
  output logic                               adm_bit,
  output logic                               adm_valid,
  output logic      [adme_pkg::SAMPLE_W-1:0] step_size,
  output logic      [adme_pkg::SAMPLE_W-1:0] estimate
);

  ////////////////////////////////////////////////////////////////////////////////
  // Shared arithmetic.

  // Multiplies by a coefficient in 1/65536 units; the shift is arithmetic so that a
  // negative estimate leaks back toward zero as well.
  function automatic logic signed [CALC_W-1:0] scale(input logic signed [CALC_W-1:0] a,
                                                     input logic [15:0]              k);
    logic signed [CALC_W+16:0] p;
    p = a * $signed({1'b0, k});
    return p[CALC_W+15:16];
  endfunction

  function automatic logic signed [CALC_W-1:0] widen(input logic [SAMPLE_W-1:0] v);
    return CALC_W'($signed(v));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic [15:0]       ctrl_q;
  logic [15:0]       step_q;
  logic [15:0]       est_q;
  logic              wr_pend_q;
  logic [11:0]       wr_addr_q;
  logic [31:0]       hrdata_q;
  logic              hreadyout_q;
  logic              hresp_q;

  wire               addr_phase;
  wire [11:0]        addr_word;
  wire               wr_ctrl;
  wire [15:0]        ctrl_now;
  wire [31:0]        rd_value;

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_word  = {haddr[11:2], 2'b00};

  // Only whole-word writes update the control word; narrower writes are ignored.
  assign wr_ctrl    = wr_pend_q && (wr_addr_q == CTRL_ADDR);

  // A read that directly follows a write to the control word must see the new value.
  assign ctrl_now   = wr_ctrl ? hwdata[15:0] : ctrl_q;

  assign rd_value   = (addr_word == CTRL_ADDR) ? {16'h0000, ctrl_now} :
                      (addr_word == STEP_ADDR) ? {16'h0000, step_q} :
                      (addr_word == EST_ADDR)  ? {16'h0000, est_q} :
                                                 32'h0000_0000;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 12'h000;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end
    else
    begin
      wr_pend_q   <= addr_phase && hwrite && (hsize == HSIZE_WORD);
      wr_addr_q   <= addr_word;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (addr_phase && !hwrite)
        hrdata_q <= rd_value;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_q <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= hwdata[15:0];
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode.

  wire [2:0]  syl_code;
  wire [1:0]  range_code;
  wire        min_sel;
  wire [1:0]  rule_code;
  wire [2:0]  est_code;
  wire [15:0] syl_k;
  wire [15:0] est_k;
  wire [2:0]  run_len;
  wire signed [CALC_W-1:0] max_ext;
  wire signed [CALC_W-1:0] min_ext;

  assign syl_code   = ctrl_q[SYL_LSB+2:SYL_LSB];
  assign range_code = ctrl_q[RANGE_LSB+1:RANGE_LSB];
  assign min_sel    = ctrl_q[MINSEL_BIT];
  assign rule_code  = ctrl_q[RULE_LSB+1:RULE_LSB];
  assign est_code   = ctrl_q[EST_LSB+2:EST_LSB];

  assign syl_k      = syl_coef(syl_code);
  assign max_ext    = widen(max_step(range_code));
  assign min_ext    = widen(min_step(min_sel));
  assign run_len    = run_length(rule_code);
  assign est_k      = est_coef(est_code);

  ////////////////////////////////////////////////////////////////////////////////
  // Encoder datapath.

  wire                     new_bit;
  wire                     run_met;
  wire signed [CALC_W-1:0] sample_ext;
  wire signed [CALC_W-1:0] step_ext;
  wire signed [CALC_W-1:0] est_ext;
  wire signed [CALC_W-1:0] grow_raw;
  wire signed [CALC_W-1:0] decay_raw;
  wire signed [CALC_W-1:0] grow;
  wire signed [CALC_W-1:0] decay;
  wire signed [CALC_W-1:0] step_raw;
  wire signed [CALC_W-1:0] step_lim;
  wire signed [CALC_W-1:0] est_leak;
  wire signed [CALC_W-1:0] est_raw;
  wire signed [CALC_W-1:0] est_max;
  wire signed [CALC_W-1:0] est_min;
  wire [15:0]              step_d;
  wire [15:0]              est_d;

  assign sample_ext = widen(sample_in);
  assign step_ext   = widen(step_q);
  assign est_ext    = widen(est_q);
  assign new_bit    = sample_ext >= est_ext;

  adme_run_detect #(
    .HIST_W    (5)
  ) u_run (
    .mclk      (mclk),
    .rst       (rst),
    .bit_in    (new_bit),
    .bit_valid (sample_valid),
    .run_len   (run_len),
    .run_met   (run_met)
  );

  // Growth and decay share the syllabic constant. A minimum move of one keeps small
  // distances from stalling when the scaled term rounds down to zero.
  assign grow_raw  = scale(max_ext - step_ext, syl_k);
  assign decay_raw = scale(step_ext - min_ext, syl_k);
  assign grow      = (grow_raw > 0) ? grow_raw : CALC_W'(1);
  assign decay     = (decay_raw > 0) ? decay_raw : CALC_W'(1);

  assign step_raw  = run_met ? step_ext + grow : step_ext - decay;

  // Clamping also pulls the step into range after software narrows the limits.
  assign step_lim  = (step_raw > max_ext) ? max_ext :
                     (step_raw < min_ext) ? min_ext : step_raw;
  assign step_d    = step_lim[15:0];

  assign est_leak  = scale(est_ext, est_k);
  assign est_raw   = new_bit ? est_ext + step_lim - est_leak : est_ext - step_lim - est_leak;
  assign est_max   = CALC_W'(32767);
  assign est_min   = -CALC_W'(32768);
  assign est_d     = (est_raw > est_max) ? est_max[15:0] :
                     (est_raw < est_min) ? est_min[15:0] : est_raw[15:0];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      step_q    <= STEP_RESET;
      est_q     <= EST_RESET;
      adm_bit   <= 1'b0;
      adm_valid <= 1'b0;
    end
    else
    begin
      adm_valid <= sample_valid;
      if (sample_valid)
      begin
        step_q  <= step_d;
        est_q   <= est_d;
        adm_bit <= new_bit;
      end
    end
  end

  assign step_size = step_q;
  assign estimate  = est_q;

endmodule
`default_nettype wire

// ==== verif/adme_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module adme_chk
  import adme_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] sample_in,
  input wire logic        sample_valid,
  input wire logic        adm_bit,
  input wire logic        adm_valid,
  input wire logic [15:0] step_size,
  input wire logic [15:0] estimate
);
  localparam int KS[8] = '{384, 256, 192, 128, 96, 64, 48, 32};
  localparam int KE[5] = '{12288, 8192, 6144, 4096, 3072};
  logic        wa_q;
  logic        ra_q;
  logic        lb_q;
  logic [3:0]  rn_q;
  logic [15:0] ctrl_q;
  logic [15:0] cp_q;
  logic [15:0] sp_q;
  logic [15:0] ep_q;
  logic [15:0] si_q;
  logic        rs_q;
  logic [31:0] rv_q;
  int          mx, mn, o, k, e, g, d, ev;
  wire         acc = hsel && hready && htrans == HTRANS_NONSEQ && haddr == CTRL_ADDR;
  wire         same = rn_q != 4'h0 && adm_bit == lb_q;
  wire [3:0]   cur = same ? rn_q + 4'h1 : 4'h1;
  wire         met = cur >= {2'b00, cp_q[9:8]} + 4'h3;
  wire [2:0]   ei = cp_q[7:5] > 3'h4 ? 3'h4 : cp_q[7:5];
  // Old step, estimate and control are copies from the sampling cycle of each bit.
  assign mx = 10240 >> cp_q[12:11];
  assign mn = cp_q[10] ? 10 : 20;
  assign o = int'(sp_q);
  assign k = KS[cp_q[15:13]];
  assign e = int'($signed(ep_q));
  assign g = ((mx - o) * k) >>> 16;
  assign d = ((o - mn) * k) >>> 16;
  assign ev = e + (adm_bit ? o + 0 : 0) - ((e * KE[ei]) >>> 16);
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    sp_q <= step_size;
    ep_q <= estimate;
    cp_q <= ctrl_q;
    si_q <= sample_in;
    rv_q <= {16'h0000, haddr == STEP_ADDR ? step_size : estimate};
    if (rst)
    begin
      wa_q <= 1'b0;
      ra_q <= 1'b0;
      rs_q <= 1'b0;
      rn_q <= 4'h0;
      lb_q <= 1'b0;
      ctrl_q <= 16'h0000;
    end
    else
    begin
      wa_q <= acc && hwrite && hsize == HSIZE_WORD;
      ra_q <= acc && !hwrite;
      rs_q <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite &&
              (haddr == STEP_ADDR || haddr == EST_ADDR);
      if (wa_q)
        ctrl_q <= hwdata[15:0];
      if (adm_valid)
        lb_q <= adm_bit;
      if (adm_valid)
        rn_q <= cur > 4'h7 ? 4'h7 : cur;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_READ_CTRL: assert property (ra_q |-> hrdata == {16'h0000, ctrl_q})
    else $error("control readback differs");
  AST_STEP_MAX: assert property (adm_valid |-> int'(step_size) <= mx)
    else $error("step above maximum");
  AST_STEP_MIN: assert property (adm_valid |-> int'(step_size) >= mn)
    else $error("step below minimum");
  AST_GROW: assert property (adm_valid && met && o >= mn && o < mx
    |-> int'(step_size) == o + (g > 0 ? g : 1))
    else $error("step growth wrong");
  AST_DECAY: assert property (adm_valid && !met && o > mn && o <= mx
    |-> int'(step_size) == o - (d > 0 ? d : 1))
    else $error("step decay wrong");
  AST_EST: assert property (adm_valid |-> int'($signed(estimate)) ==
    ((ev - (adm_bit ? 0 : int'(step_size)) + (adm_bit ? int'(step_size) - o : 0)) > 32767 ? 32767
    : ((ev - (adm_bit ? 0 : int'(step_size)) + (adm_bit ? int'(step_size) - o : 0)) < -32768
    ? -32768 : (ev - (adm_bit ? 0 : int'(step_size)) + (adm_bit ? int'(step_size) - o : 0)))))
    else $error("estimate update wrong");
  AST_VALID: assert property (sample_valid |=> adm_valid)
    else $error("bit not produced after sample");
  AST_NO_BIT: assert property (!sample_valid |=> !adm_valid)
    else $error("bit produced without a sample");
  AST_BIT: assert property (adm_valid |-> adm_bit == ($signed(si_q) >= $signed(ep_q)))
    else $error("encoded bit wrong");
  AST_READ_STAT: assert property (rs_q |-> hrdata == rv_q)
    else $error("status readback differs");
  AST_HOLD: assert property (!adm_valid |-> $stable(step_size))
    else $error("step moved without a bit");
  COV_GROW: cover property (adm_valid && met && o < mx);
  COV_DECAY: cover property (adm_valid && !met && o > mn);
  COV_READ: cover property (ra_q);
endmodule
`default_nettype wire

// ==== verif/adm_encoder_adapt_config_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module adm_encoder_adapt_config_bench;
  import adme_pkg::*;
  typedef struct packed {logic [15:0] c; logic [15:0] mx; logic [15:0] mn;} adme_row_t;
  logic        mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sample_valid = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic [15:0] sample_in = 16'h0000, step_size, estimate;
  logic        hready, hresp, adm_bit, adm_valid;
  int          errors = 0, checks_done = 0;
  // Fields cycle through every defined code; the last row is the 64 kbps profile setting.
  adme_row_t   rows[9] = '{{16'h0100, 16'h2800, 16'h0014}, {16'h2e20, 16'h1400, 16'h000a},
    {16'h5340, 16'h0a00, 16'h0014}, {16'h7c60, 16'h0500, 16'h000a},
    {16'h8180, 16'h2800, 16'h0014}, {16'hae00, 16'h1400, 16'h000a},
    {16'hd320, 16'h0a00, 16'h0014}, {16'hfc5f, 16'h0500, 16'h000a},
    {16'hbd00, 16'h0500, 16'h000a}};
  always #25 mclk = ~mclk;
  adme_encoder_core DUT (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .sample_in, .sample_valid, .adm_bit,
    .adm_valid, .step_size, .estimate);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [2:0] sz,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Full-scale samples force the bit: alternating extremes can never form a run.
  task automatic feed(input logic [15:0] a, input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      sample_in <= i[0] ? b : a;
      sample_valid <= 1'b1;
      @(posedge mclk);
    end
    sample_valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500_000;
    errors++;
    close_out;
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({16'h0000, step_size}, 32'h0000_0014);
    bus(CTRL_ADDR, 1'b0, HSIZE_WORD, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("reset test done");
    foreach (rows[i])
    begin
      bus(CTRL_ADDR, 1'b1, HSIZE_WORD, {16'hffff, rows[i].c});
      bus(CTRL_ADDR, 1'b0, HSIZE_WORD, 32'h0000_0000);
      chk(rd, {16'h0000, rows[i].c});
      feed(16'h7fff, 16'h7fff, 40);
      chk({31'h0000_0000, step_size <= rows[i].mx}, 32'h0000_0001);
      feed(16'h8000, 16'h7fff, 40);
      chk({31'h0000_0000, step_size >= rows[i].mn}, 32'h0000_0001);
    end
    $display("table test done");
    bus(CTRL_ADDR, 1'b1, HSIZE_WORD, 32'h0000_1c00);
    feed(16'h7fff, 16'h7fff, 1000);
    chk({16'h0000, step_size}, 32'h0000_0500);
    bus(STEP_ADDR, 1'b0, HSIZE_WORD, 32'h0000_0000);
    chk(rd, 32'h0000_0500);
    bus(EST_ADDR, 1'b0, HSIZE_WORD, 32'h0000_0000);
    chk({rd[31:16], 16'h0000}, 32'h0000_0000);
    feed(16'h8000, 16'h7fff, 1000);
    chk({16'h0000, step_size}, 32'h0000_000a);
    $display("limit test done");
    bus(12'h100, 1'b0, HSIZE_WORD, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(CTRL_ADDR, 1'b1, 3'h0, 32'h0000_ffff);
    bus(CTRL_ADDR, 1'b0, HSIZE_WORD, 32'h0000_0000);
    chk(rd, 32'h0000_1c00);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    $display("bus test done");
    // Reset is held for several cycles so that no check sees a step taken under reset.
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({16'h0000, step_size}, 32'h0000_0014);
    bus(CTRL_ADDR, 1'b0, HSIZE_WORD, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    feed(16'h7fff, 16'h7fff, 8);
    chk({31'h0000_0000, step_size > 16'h0014}, 32'h0000_0001);
    $display("mid-run reset test done");
    close_out;
  end
endmodule
bind adme_encoder_core adme_chk u_chk (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .sample_in, .sample_valid, .adm_bit, .adm_valid, .step_size,
  .estimate);
`default_nettype wire
